/* simc_pkg.sv */
// constants, types and carriers of the standby / isolation mode controller
// ============================================================
// How it works
// - low flow past standby-on delay with standby request enters standby pressure
// - standby with auto isolation enters isolation after isolation delay
// - standby request dropping in standby or isolation returns to operation
// - request back within standby-off window returns to standby at once
// - inactive effective isolation input forces isolation from any mode
// - flow below-threshold comparison uses a hysteresis band
// - normally open polarity inverts the isolation request
// - electrical regulator ramps target up to operation pressure over ramp time
// - each request comes from process data or its digital input
// - switch 1 picks control source, per base or remote unit
// - switch 2 picks regulator type, switch 3 picks polarity
// - switches 1 to 3 sampled only once after power-up
// - base accepts process data only from the channel switch 1 selects
// - spare port runs as input plus IO-Link, input plus output, or two inputs
// - wireless base pairs at most ten remote units
package simc_pkg;

	// ============================================================
	// timing
	localparam int unsigned CLK_HZ      = 125_000_000;
	localparam int unsigned TICK_US     = 1000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned PRE_W       = 17;

	// ============================================================
	// widths and limits
	localparam int unsigned VAL_W       = 16;
	localparam logic [3:0]  MAX_REMOTES = 4'hA;
	localparam logic [15:0] CNT_MAX     = 16'hFFFF;

	// ============================================================
	// modes
	typedef enum logic [1:0] {
		MODE_OPER = 2'b00,
		MODE_STBY = 2'b01,
		MODE_ISO  = 2'b10
	} simc_mode_type;

	typedef enum logic [1:0] {
		PORT_IN_LINK = 2'b00,
		PORT_IN_OUT  = 2'b01,
		PORT_IN_IN   = 2'b10
	} simc_port_type;

	localparam simc_mode_type MODE_RST = MODE_OPER;

	// ============================================================
	// carriers
	typedef struct packed {
		logic [15:0] flow_thr;
		logic [15:0] flow_hyst;
		logic [15:0] on_ms;
		logic [15:0] iso_ms;
		logic [15:0] off_ms;
		logic [15:0] ramp_ms;
		logic [15:0] oper_press;
		logic [15:0] stby_press;
		logic        auto_iso;
	} simc_cfg_type;

	typedef struct packed {
		logic remote_unit;
		logic sw_source;
		logic sw_reg_elec;
		logic sw_pol_no;
	} simc_strap_type;

	localparam simc_strap_type STRAP_RST = 4'h0;

	typedef struct packed {
		logic digital_in_stby;
		logic digital_in_iso;
		logic eth_stby;
		logic eth_iso;
		logic opcua_stby;
		logic opcua_iso;
		logic wl_stby;
		logic wl_iso;
		logic stby_from_pd;
		logic iso_from_pd;
	} simc_req_type;

endpackage

/* simc_ctrl.sv */
// standby / isolation mode controller of the air management hub
`timescale 1ns/100ps
module simc_ctrl #(
	parameter int unsigned TICK_CYCLES = simc_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rst_b,
	// switches and unit type
	input  wire simc_pkg::simc_strap_type strap_in,
	// configuration
	input  wire simc_pkg::simc_cfg_type   cfg,
	input  wire simc_pkg::simc_port_type  port_mode,
	input  wire logic                     port_do_value,
	// requests and measurement
	input  wire simc_pkg::simc_req_type   req,
	input  wire logic [15:0]              flow_rate,
	// pairing
	input  wire logic                     adapter_present,
	input  wire logic                     pair_req,
	input  wire logic                     unpair_req,
	// mode and actuators
	output simc_pkg::simc_mode_type       mode_r,
	output logic                          supply_open_r,
	output logic                          relief_valve_exhaust_r,
	output logic                          regulator_standby_r,
	output logic [15:0]                   target_press_r,
	output logic                          flow_below_r,
	output simc_pkg::simc_strap_type      straps_r,
	// spare port
	output logic                          port_iolink_en_r,
	output logic                          port_do_en_r,
	output logic                          port_do_r,
	output logic                          port_di2_en_r,
	// pairing status
	output logic [3:0]                    paired_count_r,
	output logic                          pair_ack_r,
	output logic                          pair_nak_r
);

	// ============================================================
	// helpers
	function automatic logic pick_pd(input simc_pkg::simc_strap_type s,
		input logic eth, input logic opc, input logic wl);
		if (!s.remote_unit)
			pick_pd = s.sw_source ? opc : eth;
		else
			pick_pd = s.sw_source ? 1'b0 : wl;
	endfunction

	function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic tick);
		sat_inc = (tick && v != simc_pkg::CNT_MAX) ? v + 16'h0001 : v;
	endfunction

	// ============================================================
	// state
	logic                     strap_done_r;
	logic                     strap_done_nxt;
	simc_pkg::simc_strap_type straps_nxt;
	logic [simc_pkg::PRE_W-1:0] pre_r;
	logic [simc_pkg::PRE_W-1:0] pre_nxt;
	logic                     tick_r;
	logic                     tick_nxt;
	simc_pkg::simc_mode_type  mode_nxt;
	logic                     forced_r;
	logic                     forced_nxt;
	logic                     win_r;
	logic                     win_nxt;
	logic [15:0]              on_cnt_r;
	logic [15:0]              on_cnt_nxt;
	logic [15:0]              iso_cnt_r;
	logic [15:0]              iso_cnt_nxt;
	logic [15:0]              off_cnt_r;
	logic [15:0]              off_cnt_nxt;
	logic [15:0]              ramp_cnt_r;
	logic [15:0]              ramp_cnt_nxt;
	logic [15:0]              ramp_start_r;
	logic [15:0]              ramp_start_nxt;
	logic [15:0]              target_nxt;
	logic                     below_nxt;
	logic                     supply_nxt;
	logic                     exhaust_nxt;
	logic                     reg_stby_nxt;
	logic                     iol_nxt;
	logic                     do_en_nxt;
	logic                     do_nxt;
	logic                     di2_nxt;
	logic [3:0]               pcount_nxt;
	logic                     ack_nxt;
	logic                     nak_nxt;

	// request resolution
	logic        pd_allowed;
	logic        stby_req;
	logic        iso_raw;
	logic        iso_ok;
	logic [16:0] hyst_top;
	logic [31:0] ramp_prod;
	logic [15:0] ramp_diff;

	// ============================================================
	// next values
	always_comb
	begin
		// switches are latched once so a live change cannot disturb a running machine
		strap_done_nxt = 1'b1;
		straps_nxt     = strap_done_r ? straps_r : strap_in;

		pre_nxt  = (pre_r == simc_pkg::PRE_W'(TICK_CYCLES - 1)) ? '0 : pre_r + 1'b1;
		tick_nxt = (pre_r == simc_pkg::PRE_W'(TICK_CYCLES - 1));

		pd_allowed = !(straps_r.remote_unit && straps_r.sw_source);
		stby_req   = (req.stby_from_pd && pd_allowed)
			? pick_pd(straps_r, req.eth_stby, req.opcua_stby, req.wl_stby)
			: req.digital_in_stby;
		iso_raw    = (req.iso_from_pd && pd_allowed)
			? pick_pd(straps_r, req.eth_iso, req.opcua_iso, req.wl_iso)
			: req.digital_in_iso;
		iso_ok     = straps_r.sw_pol_no ? ~iso_raw : iso_raw;

		// narrow band would chatter standby entry; hold below until thr + hyst
		hyst_top  = {1'b0, cfg.flow_thr} + {1'b0, cfg.flow_hyst};
		below_nxt = flow_below_r ? ({1'b0, flow_rate} < hyst_top)
			: (flow_rate < cfg.flow_thr);

		mode_nxt   = mode_r;
		forced_nxt = forced_r;
		win_nxt    = win_r;
		// reset-time switch values must not trip a forced isolation
		if (!iso_ok && strap_done_r)
		begin
			mode_nxt   = simc_pkg::MODE_ISO;
			forced_nxt = 1'b1;
			win_nxt    = 1'b0;
		end
		else
		begin
			case (mode_r)
				simc_pkg::MODE_OPER:
				begin
					if (stby_req && win_r)
						mode_nxt = simc_pkg::MODE_STBY;
					else if (stby_req && flow_below_r && on_cnt_r >= cfg.on_ms)
						mode_nxt = simc_pkg::MODE_STBY;
					if (win_r && off_cnt_r >= cfg.off_ms)
						win_nxt = 1'b0;
					if (mode_nxt != simc_pkg::MODE_OPER)
						win_nxt = 1'b0;
				end
				simc_pkg::MODE_STBY:
				begin
					if (!stby_req)
					begin
						mode_nxt = simc_pkg::MODE_OPER;
						win_nxt  = 1'b1;
					end
					else if (cfg.auto_iso && iso_cnt_r >= cfg.iso_ms)
						mode_nxt = simc_pkg::MODE_ISO;
				end
				default:
				begin
					forced_nxt = 1'b0;
					if (!stby_req)
					begin
						mode_nxt = simc_pkg::MODE_OPER;
						win_nxt  = !forced_r;
					end
					else if (forced_r)
						mode_nxt = simc_pkg::MODE_STBY;
				end
			endcase
		end

		// each timer clears the moment its condition drops
		on_cnt_nxt  = (mode_r == simc_pkg::MODE_OPER && stby_req && flow_below_r)
			? sat_inc(on_cnt_r, tick_r) : '0;
		iso_cnt_nxt = (mode_r == simc_pkg::MODE_STBY && cfg.auto_iso)
			? sat_inc(iso_cnt_r, tick_r) : '0;
		off_cnt_nxt = (mode_r == simc_pkg::MODE_OPER && win_r)
			? sat_inc(off_cnt_r, tick_r) : '0;

		ramp_start_nxt = ramp_start_r;
		ramp_cnt_nxt   = (mode_r == simc_pkg::MODE_OPER) ? sat_inc(ramp_cnt_r, tick_r) : '0;
		if (mode_r != simc_pkg::MODE_OPER && mode_nxt == simc_pkg::MODE_OPER)
		begin
			ramp_start_nxt = target_press_r;
			ramp_cnt_nxt   = '0;
		end

		// linear ramp; a target already above operation pressure drops at once
		ramp_diff = cfg.oper_press - ramp_start_r;
		ramp_prod = {16'h0000, ramp_diff} * {16'h0000, ramp_cnt_r};
		case (mode_r)
			simc_pkg::MODE_OPER:
			begin
				if (straps_r.sw_reg_elec && cfg.ramp_ms != 16'h0000
					&& ramp_cnt_r < cfg.ramp_ms && cfg.oper_press > ramp_start_r)
					target_nxt = ramp_start_r
						+ 16'(ramp_prod / {16'h0000, cfg.ramp_ms});
				else
					target_nxt = cfg.oper_press;
			end
			simc_pkg::MODE_STBY:
				target_nxt = cfg.stby_press;
			default:
				target_nxt = target_press_r;
		endcase

		supply_nxt   = (mode_nxt != simc_pkg::MODE_ISO);
		exhaust_nxt  = (mode_nxt == simc_pkg::MODE_ISO);
		reg_stby_nxt = (mode_nxt == simc_pkg::MODE_STBY);

		iol_nxt   = (port_mode == simc_pkg::PORT_IN_LINK);
		do_en_nxt = (port_mode == simc_pkg::PORT_IN_OUT);
		do_nxt    = do_en_nxt && port_do_value;
		di2_nxt   = (port_mode == simc_pkg::PORT_IN_IN);

		pcount_nxt = paired_count_r;
		ack_nxt    = 1'b0;
		nak_nxt    = 1'b0;
		if (pair_req)
		begin
			if (!straps_r.remote_unit && adapter_present
				&& paired_count_r < simc_pkg::MAX_REMOTES)
			begin
				pcount_nxt = paired_count_r + 4'h1;
				ack_nxt    = 1'b1;
			end
			else
				nak_nxt = 1'b1;
		end
		else if (unpair_req && paired_count_r != 4'h0)
			pcount_nxt = paired_count_r - 4'h1;
	end

	// ============================================================
	// registers
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			strap_done_r           <= 1'b0;
			straps_r               <= simc_pkg::STRAP_RST;
			pre_r                  <= '0;
			tick_r                 <= 1'b0;
			mode_r                 <= simc_pkg::MODE_RST;
			forced_r               <= 1'b0;
			win_r                  <= 1'b0;
			on_cnt_r               <= '0;
			iso_cnt_r              <= '0;
			off_cnt_r              <= '0;
			ramp_cnt_r             <= '0;
			ramp_start_r           <= '0;
			target_press_r         <= '0;
			flow_below_r           <= 1'b0;
			supply_open_r          <= 1'b1;
			relief_valve_exhaust_r <= 1'b0;
			regulator_standby_r    <= 1'b0;
			port_iolink_en_r       <= 1'b0;
			port_do_en_r           <= 1'b0;
			port_do_r              <= 1'b0;
			port_di2_en_r          <= 1'b0;
			paired_count_r         <= 4'h0;
			pair_ack_r             <= 1'b0;
			pair_nak_r             <= 1'b0;
		end
		else
		begin
			strap_done_r           <= strap_done_nxt;
			straps_r               <= straps_nxt;
			pre_r                  <= pre_nxt;
			tick_r                 <= tick_nxt;
			mode_r                 <= mode_nxt;
			forced_r               <= forced_nxt;
			win_r                  <= win_nxt;
			on_cnt_r               <= on_cnt_nxt;
			iso_cnt_r              <= iso_cnt_nxt;
			off_cnt_r              <= off_cnt_nxt;
			ramp_cnt_r             <= ramp_cnt_nxt;
			ramp_start_r           <= ramp_start_nxt;
			target_press_r         <= target_nxt;
			flow_below_r           <= below_nxt;
			supply_open_r          <= supply_nxt;
			relief_valve_exhaust_r <= exhaust_nxt;
			regulator_standby_r    <= reg_stby_nxt;
			port_iolink_en_r       <= iol_nxt;
			port_do_en_r           <= do_en_nxt;
			port_do_r              <= do_nxt;
			port_di2_en_r          <= di2_nxt;
			paired_count_r         <= pcount_nxt;
			pair_ack_r             <= ack_nxt;
			pair_nak_r             <= nak_nxt;
		end
	end

endmodule // simc_ctrl

/* simc_ctrl_properties.sv */
// assertions on the mode controller ports
`timescale 1ns/100ps
module simc_ctrl_properties (
	// clock and reset
	input wire logic                     sys_clk,
	input wire logic                     rst_b,
	// inputs
	input wire simc_pkg::simc_cfg_type   cfg,
	input wire simc_pkg::simc_port_type  port_mode,
	input wire simc_pkg::simc_req_type   req,
	input wire logic [15:0]              flow_rate,
	input wire logic                     adapter_present,
	input wire logic                     pair_req,
	// outputs
	input wire simc_pkg::simc_mode_type  mode_r,
	input wire logic                     supply_open_r,
	input wire logic                     relief_valve_exhaust_r,
	input wire logic                     regulator_standby_r,
	input wire logic [15:0]              target_press_r,
	input wire logic                     flow_below_r,
	input wire simc_pkg::simc_strap_type straps_r,
	input wire logic                     port_do_en_r,
	input wire logic [3:0]               paired_count_r,
	input wire logic                     pair_ack_r,
	input wire logic                     pair_nak_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// ============================================================
	// straps latched on the first edge, so stability is checked after it
	logic seen_r;
	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b) seen_r <= 1'b0; else seen_r <= 1'b1;
	// ============================================================
	// properties
	iso_force_a: assert property (seen_r && !req.iso_from_pd
		&& !(req.digital_in_iso ^ straps_r.sw_pol_no) |=> mode_r == simc_pkg::MODE_ISO)
		else $error("forced isolation missed");
	boot_oper_a: assert property (!seen_r |=> mode_r == simc_pkg::MODE_OPER)
		else $error("mode moved before switches latched");
	iso_outs_a: assert property (mode_r == simc_pkg::MODE_ISO
		|-> !supply_open_r && relief_valve_exhaust_r) else $error("isolation valves wrong");
	oper_outs_a: assert property (mode_r == simc_pkg::MODE_OPER
		|-> supply_open_r && !relief_valve_exhaust_r && !regulator_standby_r) else $error("oper outs");
	stby_out_a: assert property (mode_r == simc_pkg::MODE_STBY
		|-> regulator_standby_r && supply_open_r) else $error("standby outputs wrong");
	stby_press_a: assert property ($rose(regulator_standby_r)
		|=> target_press_r == cfg.stby_press) else $error("standby pressure not applied");
	flow_set_a: assert property (flow_rate < cfg.flow_thr
		|=> flow_below_r) else $error("low flow not flagged");
	flow_clr_a: assert property ({1'b0, flow_rate} >= {1'b0, cfg.flow_thr} + {1'b0, cfg.flow_hyst}
		|=> !flow_below_r) else $error("low flow not cleared");
	straps_hold_a: assert property (seen_r |=> $stable(straps_r))
		else $error("switches changed after power-up");
	pair_ok_a: assert property (pair_req && adapter_present && !straps_r.remote_unit
		&& paired_count_r < 4'hA |=> pair_ack_r && paired_count_r == $past(paired_count_r) + 4'h1)
		else $error("pairing not accepted");
	pair_full_a: assert property (pair_req && paired_count_r == 4'hA
		|=> pair_nak_r && paired_count_r == 4'hA) else $error("eleventh remote accepted");
	port_do_a: assert property (port_mode == simc_pkg::PORT_IN_OUT |=> port_do_en_r)
		else $error("output port not enabled");
	c_stby: cover property (mode_r == simc_pkg::MODE_STBY);
	c_iso: cover property (mode_r == simc_pkg::MODE_ISO);
	c_nak: cover property (pair_nak_r);
endmodule // simc_ctrl_properties

bind simc_ctrl simc_ctrl_properties u_prop (
	.sys_clk                (sys_clk),
	.rst_b                  (rst_b),
	.cfg                    (cfg),
	.port_mode              (port_mode),
	.req                    (req),
	.flow_rate              (flow_rate),
	.adapter_present        (adapter_present),
	.pair_req               (pair_req),
	.mode_r                 (mode_r),
	.supply_open_r          (supply_open_r),
	.relief_valve_exhaust_r (relief_valve_exhaust_r),
	.regulator_standby_r    (regulator_standby_r),
	.target_press_r         (target_press_r),
	.flow_below_r           (flow_below_r),
	.straps_r               (straps_r),
	.port_do_en_r           (port_do_en_r),
	.paired_count_r         (paired_count_r),
	.pair_ack_r             (pair_ack_r),
	.pair_nak_r             (pair_nak_r)
);

/* simc_plc_model.sv */
// machine controller model driving the request carrier
`timescale 1ns/100ps
module simc_plc_model (
	// commands from the bench
	input wire logic                     stby,
	input wire logic                     iso,
	input wire logic [1:0]               ch,
	// requests to the hub
	output simc_pkg::simc_req_type       req
);
	// unselected channels carry the inverse, so a wrong source shows at once
	function automatic logic sel(input logic [1:0] k, input logic v);
		return (ch == k) ? v : !v;
	endfunction
	always_comb
	begin
		req.digital_in_stby = sel(2'h0, stby);
		req.digital_in_iso  = sel(2'h0, iso);
		req.eth_stby        = sel(2'h1, stby);
		req.eth_iso         = sel(2'h1, iso);
		req.opcua_stby      = sel(2'h2, stby);
		req.opcua_iso       = sel(2'h2, iso);
		req.wl_stby         = sel(2'h3, stby);
		req.wl_iso          = sel(2'h3, iso);
		req.stby_from_pd    = (ch != 2'h0);
		req.iso_from_pd     = (ch != 2'h0);
	end
endmodule // simc_plc_model

/* test_simc_ctrl.sv */
// self-checking bench for the mode controller
`timescale 1ns/100ps
module test_simc_ctrl;
	localparam int unsigned TK = 4;
	logic sys_clk, rst_b, port_do_value, adapter_present, pair_req, unpair_req, stby, iso;
	logic supply_open_r, relief_valve_exhaust_r, regulator_standby_r, flow_below_r;
	logic port_iolink_en_r, port_do_en_r, port_do_r, port_di2_en_r, pair_ack_r, pair_nak_r;
	logic [1:0] ch;
	logic [3:0] paired_count_r;
	logic [15:0] flow_rate, target_press_r;
	simc_pkg::simc_strap_type strap_in, straps_r;
	simc_pkg::simc_cfg_type cfg;
	simc_pkg::simc_port_type port_mode;
	simc_pkg::simc_req_type req;
	simc_pkg::simc_mode_type mode_r;
	int num_errors, n_tests;
	logic [3:0] rs [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h1};
	logic [1:0] rc [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};

	simc_ctrl #(.TICK_CYCLES(TK)) uut (.*);
	simc_plc_model plc (.*);

	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = !sys_clk;
	end
	// ============================================================
	// tasks
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic final_report();
		if (num_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_mode(input simc_pkg::simc_mode_type exp);
		chk_val({14'h0, mode_r}, {14'h0, exp});
	endtask
	task automatic wait_mode(input simc_pkg::simc_mode_type exp, input int n);
		for (int i = 0; i < n && mode_r !== exp; i++)
			tick(1);
		chk_mode(exp);
		if (mode_r !== exp)
			final_report();
	endtask
	task automatic restart(input logic [3:0] s);
		rst_b = 1'b0;
		strap_in = s;
		tick(5);
		rst_b = 1'b1;
		tick(2);
	endtask
	// ============================================================
	// sequence
	initial
	begin
		num_errors = 0;
		n_tests = 0;
		rst_b = 1'b0;
		strap_in = 4'h0;
		{port_do_value, adapter_present, pair_req, unpair_req, stby, iso} = 6'b110001;
		ch = 2'h1;
		flow_rate = 16'h01F4;
		port_mode = simc_pkg::PORT_IN_LINK;
		cfg = '{16'h0064, 16'h0014, 16'h0003, 16'h0003, 16'h0005, 16'h0000, 16'h03E8, 16'h012C, 1'b1};
		tick(2);
		chk_val({supply_open_r, relief_valve_exhaust_r, regulator_standby_r, target_press_r[12:0]}, 16'h8000);
		tick(3);
		rst_b = 1'b1;
		tick(2);
		flow_rate = 16'h006E;
		tick(3);
		chk_val({15'h0, flow_below_r}, 16'h0000);
		flow_rate = 16'h0032;
		tick(2);
		flow_rate = 16'h006E;
		tick(3);
		chk_val({15'h0, flow_below_r}, 16'h0001);
		flow_rate = 16'h0078;
		tick(2);
		chk_val({15'h0, flow_below_r}, 16'h0000);
		stby = 1'b1;
		repeat (4)
		begin
			flow_rate = 16'h0032;
			tick(6);
			flow_rate = 16'h01F4;
			tick(3);
		end
		chk_mode(simc_pkg::MODE_OPER);
		flow_rate = 16'h0032;
		tick(6);
		chk_mode(simc_pkg::MODE_OPER);
		wait_mode(simc_pkg::MODE_STBY, 30);
		tick(2);
		chk_val(target_press_r, 16'h012C);
		wait_mode(simc_pkg::MODE_ISO, 30);
		chk_val({14'h0, supply_open_r, relief_valve_exhaust_r}, 16'h0001);
		stby = 1'b0;
		wait_mode(simc_pkg::MODE_OPER, 3);
		tick(2);
		chk_val(target_press_r, 16'h03E8);
		flow_rate = 16'h01F4;
		stby = 1'b1;
		wait_mode(simc_pkg::MODE_STBY, 3);
		stby = 1'b0;
		wait_mode(simc_pkg::MODE_OPER, 3);
		tick(40);
		stby = 1'b1;
		tick(30);
		chk_mode(simc_pkg::MODE_OPER);
		stby = 1'b0;
		iso = 1'b0;
		wait_mode(simc_pkg::MODE_ISO, 3);
		iso = 1'b1;
		wait_mode(simc_pkg::MODE_OPER, 3);
		for (int m = 0; m < 3; m++)
		begin
			port_mode = simc_pkg::simc_port_type'(m);
			tick(2);
			chk_val({12'h0, port_iolink_en_r, port_do_en_r, port_do_r, port_di2_en_r},
				(m == 0) ? 16'h0008 : (m == 1) ? 16'h0006 : 16'h0001);
		end
		chk_val({15'h0, port_di2_en_r | port_do_r}, 16'h0001);
		pair_req = 1'b1;
		for (int i = 1; i < 12; i++)
		begin
			tick(1);
			chk_val({10'h0, pair_ack_r, pair_nak_r, paired_count_r}, (i < 11) ? 16'h20 | i : 16'h1A);
		end
		pair_req = 1'b0;
		unpair_req = 1'b1;
		tick(1);
		unpair_req = 1'b0;
		tick(1);
		chk_val({10'h0, pair_ack_r, pair_nak_r, paired_count_r}, 16'h0009);
		for (int r = 0; r < 5; r++)
		begin
			ch = rc[r];
			iso = !rs[r][0];
			restart(rs[r]);
			strap_in = ~rs[r];
			tick(10);
			chk_val({12'h0, straps_r}, {12'h0, rs[r]});
			chk_mode(simc_pkg::MODE_OPER);
			iso = !iso;
			wait_mode(simc_pkg::MODE_ISO, 3);
		end
		cfg.ramp_ms = 16'h0004;
		ch = 2'h0;
		iso = 1'b1;
		restart(4'h3);
		wait_mode(simc_pkg::MODE_ISO, 3);
		iso = 1'b0;
		wait_mode(simc_pkg::MODE_OPER, 3);
		tick(10);
		chk_val({15'h0, target_press_r > 16'h0 && target_press_r < 16'h03E8}, 16'h0001);
		tick(30);
		chk_val(target_press_r, 16'h03E8);
		final_report();
	end
endmodule // test_simc_ctrl
